//--- paf_top.v
// AND-OR array fabric with cells, signature, security and test access
`include "paf_consts.vh"
module paf_top (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Avalon-MM slave
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Dedicated input pins
	input wire [9:0] in_pin,
	// Output-cell pins
	input wire [9:0] io_pin_in,
	output wire [9:0] io_pin_out,
	output wire [9:0] io_pin_oe,
	// Clock pins
	input wire input_register_clock,
	input wire output_register_clock
);
	integer k;
	reg [77:0] and_q [0:74];
	reg [63:0] or_q [0:35];
	reg [71:0] sig_q;
	reg [9:0] asel_q;
	reg [6:0] osel_q;
	reg [1:0] ssel_q;
	reg [31:0] csum_q;
	reg [31:0] plo_q;
	reg [5:0] phi_q;
	reg secure_q;
	reg diag_q;
	reg ack_q;
	reg [7:0] pur_q;
	reg ready_q;
	reg pre_go_q;
	reg [9:0] in_q;
	reg [9:0] io_q;
	reg [17:0] cell_q;
	wire [21:0] pin_s;
	wire [21:0] pin_r;
	wire [38:0] sig39;
	wire [77:0] lit;
	wire [74:0] pt;
	wire [35:0] sum;
	wire [37:0] pre_val;
	wire req;
	wire take;
	wire wr;
	wire a_ok;
	wire o_ok;
	wire [6:0] a_t;
	wire [1:0] a_w;
	wire [5:0] o_t;
	wire o_w;
	reg [31:0] and_word;
	reg [31:0] or_word;
	reg [31:0] sig_word;
	reg [31:0] rd_d;

	paf_sync #(
		.W(22)
	) u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.d({output_register_clock, input_register_clock, io_pin_in, in_pin}),
		.q(pin_s),
		.rise(pin_r)
	);

	// Input clock level feeds the array as the 39th signal
	assign sig39 = {pin_s[20], cell_q[9:0], cell_q[17:10], io_q, in_q};
	assign lit = {~sig39, sig39};

	genvar g;
	generate
		for (g = 0; g < `PAF_NPT; g = g + 1)
		begin : g_pt
			paf_pterm u_pt (
				.lit(lit),
				.fuse(and_q[g]),
				.term(pt[g])
			);
		end
		for (g = 0; g < `PAF_NSUM; g = g + 1)
		begin : g_sum
			// Any subset of the 64 terms may feed the sum
			assign sum[g] = |(pt[`PAF_NOR-1:0] & or_q[g]);
		end
	endgenerate

	// Pins: registered output inverted, so reset state drives high
	assign io_pin_out = ~cell_q[9:0];
	assign io_pin_oe = pt[`PAF_PT_OE+9:`PAF_PT_OE];

	// Bus handshake: one wait cycle per access
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign take = req & ack_q;
	assign wr = avs_write & take;

	assign a_t = asel_q[6:0];
	assign a_w = asel_q[9:8];
	assign a_ok = (a_t < `PAF_NPT) && (a_w != 2'h3);
	assign o_t = osel_q[5:0];
	assign o_w = osel_q[6];
	assign o_ok = (o_t < `PAF_NSUM);
	assign pre_val = {phi_q, plo_q};

	always @*
	begin
		and_word = 32'h0;
		if (a_ok)
		begin
			case (a_w)
				2'h0: and_word = and_q[a_t][31:0];
				2'h1: and_word = and_q[a_t][63:32];
				default: and_word = {18'h0, and_q[a_t][77:64]};
			endcase
		end
		or_word = 32'h0;
		if (o_ok)
			or_word = o_w ? or_q[o_t][63:32] : or_q[o_t][31:0];
		case (ssel_q)
			2'h0: sig_word = sig_q[31:0];
			2'h1: sig_word = sig_q[63:32];
			2'h2: sig_word = {24'h0, sig_q[71:64]};
			default: sig_word = 32'h0;
		endcase
	end

	always @*
	begin
		rd_d = 32'h0;
		case (avs_address)
			`PAF_A_CTRL: rd_d = {28'h0, diag_q, 2'h0, secure_q};
			`PAF_A_STAT: rd_d = {30'h0, ready_q, secure_q};
			`PAF_A_ASEL: rd_d = {22'h0, asel_q};
			// Product-term array read-back blocked while secured
			`PAF_A_ADAT: rd_d = secure_q ? 32'h0 : and_word;
			`PAF_A_OSEL: rd_d = {25'h0, osel_q};
			`PAF_A_ODAT: rd_d = or_word;
			`PAF_A_SSEL: rd_d = {30'h0, ssel_q};
			`PAF_A_SDAT: rd_d = sig_word;
			`PAF_A_CSUM: rd_d = csum_q;
			`PAF_A_PLO: rd_d = plo_q;
			`PAF_A_PHI: rd_d = {26'h0, phi_q};
			// Diagnostics view of output and buried registers
			`PAF_A_DIAG: rd_d = diag_q ? {14'h0, cell_q} : 32'h0;
			default: rd_d = 32'h0;
		endcase
	end

	// Read data captured on the first cycle, stands at the ack edge
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_q <= 1'b0;
			avs_readdata <= 32'h0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (avs_read & ~ack_q)
				avs_readdata <= rd_d;
		end
	end

	// Control, selectors and preload data
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			secure_q <= 1'b0;
			diag_q <= 1'b0;
			pre_go_q <= 1'b0;
			asel_q <= 10'h0;
			osel_q <= 7'h0;
			ssel_q <= 2'h0;
			plo_q <= 32'h0;
			phi_q <= 6'h0;
		end
		else
		begin
			pre_go_q <= 1'b0;
			if (wr)
			begin
				case (avs_address)
					`PAF_A_CTRL:
					begin
						// Erase beats a same-write secure request
						if (avs_writedata[`PAF_B_ERASE])
							secure_q <= 1'b0;
						else if (avs_writedata[`PAF_B_SECURE])
							secure_q <= 1'b1;
						diag_q <= avs_writedata[`PAF_B_DIAG];
						pre_go_q <= avs_writedata[`PAF_B_PRELOAD];
					end
					`PAF_A_ASEL: asel_q <= avs_writedata[9:0];
					`PAF_A_OSEL: osel_q <= avs_writedata[6:0];
					`PAF_A_SSEL: ssel_q <= avs_writedata[1:0];
					`PAF_A_PLO: plo_q <= avs_writedata;
					`PAF_A_PHI: phi_q <= avs_writedata[5:0];
					default: ;
				endcase
			end
		end
	end

	// Configuration store and running checksum
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (k = 0; k < `PAF_NPT; k = k + 1)
				and_q[k] <= 78'h0;
			for (k = 0; k < `PAF_NSUM; k = k + 1)
				or_q[k] <= 64'h0;
			sig_q <= 72'h0;
			csum_q <= 32'h0;
		end
		else if (wr && avs_address == `PAF_A_CTRL &&
			avs_writedata[`PAF_B_ERASE])
		begin
			for (k = 0; k < `PAF_NPT; k = k + 1)
				and_q[k] <= 78'h0;
			for (k = 0; k < `PAF_NSUM; k = k + 1)
				or_q[k] <= 64'h0;
			sig_q <= 72'h0;
			csum_q <= 32'h0;
		end
		else if (wr)
		begin
			case (avs_address)
				`PAF_A_ADAT:
					if (a_ok)
					begin
						case (a_w)
							2'h0: and_q[a_t][31:0] <= avs_writedata;
							2'h1: and_q[a_t][63:32] <= avs_writedata;
							default: and_q[a_t][77:64] <= avs_writedata[13:0];
						endcase
						if (a_w == 2'h2)
							csum_q <= csum_q - and_word +
								{18'h0, avs_writedata[13:0]};
						else
							csum_q <= csum_q - and_word + avs_writedata;
					end
				`PAF_A_ODAT:
					if (o_ok)
					begin
						if (o_w)
							or_q[o_t][63:32] <= avs_writedata;
						else
							or_q[o_t][31:0] <= avs_writedata;
						csum_q <= csum_q - or_word + avs_writedata;
					end
				`PAF_A_SDAT:
				begin
					// Signature words count in the checksum too
					case (ssel_q)
						2'h0:
						begin
							sig_q[31:0] <= avs_writedata;
							csum_q <= csum_q - sig_word + avs_writedata;
						end
						2'h1:
						begin
							sig_q[63:32] <= avs_writedata;
							csum_q <= csum_q - sig_word + avs_writedata;
						end
						2'h2:
						begin
							sig_q[71:64] <= avs_writedata[7:0];
							csum_q <= csum_q - sig_word +
								{24'h0, avs_writedata[7:0]};
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	// Power-up hold: cells stay cleared and clocks are ignored
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pur_q <= 8'h0;
			ready_q <= 1'b0;
		end
		else if (!ready_q)
		begin
			// Hold length is the 1 us maximum, rounded down
			if (pur_q == `PAF_PUR_CYC - 1)
				ready_q <= 1'b1;
			pur_q <= pur_q + 8'h01;
		end
	end

	// Input-side cells: sample on input register clock
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			in_q <= 10'h0;
			io_q <= 10'h0;
		end
		else if (!ready_q)
		begin
			in_q <= 10'h0;
			io_q <= 10'h0;
		end
		else if (pre_go_q)
		begin
			in_q <= pre_val[9:0];
			io_q <= pre_val[19:10];
		end
		else if (pin_r[20])
		begin
			// Clock edges before ready are dropped
			in_q <= pin_s[9:0];
			io_q <= pin_s[19:10];
		end
	end

	// Output and buried cells: D/E registers on output clock
	generate
		for (g = 0; g < `PAF_NCELL; g = g + 1)
		begin : g_cell
			always @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
					cell_q[g] <= 1'b0;
				else if (!ready_q)
					cell_q[g] <= 1'b0;
				else if (pre_go_q)
					cell_q[g] <= pre_val[20+g];
				else if (pt[`PAF_PT_RESET])
					cell_q[g] <= 1'b0;
				else if (pin_r[21] && sum[`PAF_SUM_E+g])
					cell_q[g] <= sum[g];
			end
		end
	endgenerate
endmodule // paf_top

//--- paf_consts.vh
// Constants for the programmable AND-OR array fabric
// Behaviour
// - Product-term array: 78 true/complement literals give 75 terms.
// - Literals come from 39 signals: cells, feedbacks and input clock.
// - Ten product terms are per-pin output enables for the output cells.
// - One dedicated product term resets output and buried registers.
// - Sum-term array takes 64 product terms and gives 36 sums.
// - 18 data and 18 enable sums, one of each per output or buried cell.
// - Each sum may connect any number of product terms, zero to 64.
// - A 72-bit user signature store is provided.
// - The signature stays readable whether or not security is set.
// - Configuration checksum covers the signature contents.
// - With security set, product-term array read-back is refused.
// - Security clears only through full bulk erase.
// - Every cell register can be preloaded with a forced value.
// - Diagnostics mode reads out the output and buried registers.
// - Power-up reset clears all registers within 1 us.
// - After reset, enabled registered outputs drive high.
// - Undriven inputs and tri-stated pins read as logic one.
`ifndef PAF_CONSTS_VH
`define PAF_CONSTS_VH
`define PAF_NLIT 78
`define PAF_NPT 75
`define PAF_NOR 64
`define PAF_NSUM 36
`define PAF_NCELL 18
`define PAF_NOUT 10
`define PAF_PT_RESET 64
`define PAF_PT_OE 65
`define PAF_SUM_E 18
`define PAF_SIG_W 72
`define PAF_PUR_NS 1000
`define PAF_CLK_MHZ 200
`define PAF_PUR_CYC ((`PAF_PUR_NS * `PAF_CLK_MHZ) / 1000)
`define PAF_A_CTRL 8'h00
`define PAF_A_STAT 8'h04
`define PAF_A_ASEL 8'h08
`define PAF_A_ADAT 8'h0C
`define PAF_A_OSEL 8'h10
`define PAF_A_ODAT 8'h14
`define PAF_A_SSEL 8'h18
`define PAF_A_SDAT 8'h1C
`define PAF_A_CSUM 8'h20
`define PAF_A_PLO 8'h24
`define PAF_A_PHI 8'h28
`define PAF_A_DIAG 8'h2C
`define PAF_B_SECURE 0
`define PAF_B_ERASE 1
`define PAF_B_PRELOAD 2
`define PAF_B_DIAG 3
`define PAF_B_READY 1
`endif

//--- paf_sync.v
// Three-stage input synchroniser with agreement filter
module paf_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Data
	input wire [W-1:0] d,
	output wire [W-1:0] q,
	output wire [W-1:0] rise
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg f_q;
			reg r_q;
			// Idle high models the pin pull-up
			always @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					s1_q <= 1'b1;
					s2_q <= 1'b1;
					s3_q <= 1'b1;
					f_q <= 1'b1;
					r_q <= 1'b0;
				end
				else
				begin
					s1_q <= d[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q)
						f_q <= s3_q;
					r_q <= (s2_q == s3_q) & s3_q & ~f_q;
				end
			end
			assign q[i] = f_q;
			assign rise[i] = r_q;
		end
	endgenerate
endmodule // paf_sync

//--- paf_pterm.v
// One programmable product term
module paf_pterm (
	// Literals and fuses
	input wire [77:0] lit,
	input wire [77:0] fuse,
	// Term
	output wire term
);
	// No connected literal means an unused term, forced low
	assign term = (|fuse) & (&(lit | ~fuse));
endmodule // paf_pterm

//--- paf_assertions.sv
// Bus and pin checks for the array fabric
`include "paf_consts.vh"
module paf_assertions (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Bus
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// Pins
	input wire [9:0] io_pin_out,
	input wire [9:0] io_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] up_q;
	logic sec_q;
	logic diag_q;
	wire rd = avs_read && !avs_waitrequest;
	wire st = rd && avs_address == `PAF_A_STAT;
	wire cw = avs_write && !avs_waitrequest && avs_address == `PAF_A_CTRL;
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			up_q <= 8'h00;
			sec_q <= 1'b0;
			diag_q <= 1'b0;
		end
		else
		begin
			if (up_q != 8'hFF)
				up_q <= up_q + 8'h01;
			// Erase wins over a set in the same write
			if (cw)
				sec_q <= (sec_q | avs_writedata[0]) & !avs_writedata[1];
			if (cw)
				diag_q <= avs_writedata[3];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence req_s; $rose(avs_read || avs_write); endsequence
	sequence ans_s; avs_waitrequest ##1 !avs_waitrequest; endsequence
	wait_one_a: assert property (req_s |-> ans_s)
		else $error("bus answer late");
	rst_pins_a: assert property ($rose(rst_b) |->
		(io_pin_out == 10'h3FF && io_pin_oe == 10'h000) [*8])
		else $error("pins not idle after reset");
	hold_pins_a: assert property (up_q < 8'd190 |->
		io_pin_out == 10'h3FF) else $error("cells moved in hold");
	ready_lo_a: assert property (st && up_q < 8'd190 |->
		!avs_readdata[1]) else $error("ready too early");
	ready_hi_a: assert property (st && up_q > 8'd210 |->
		avs_readdata[1]) else $error("ready missing");
	sec_bit_a: assert property (st |->
		avs_readdata[0] == sec_q) else $error("secure bit wrong");
	sec_hide_a: assert property (rd && sec_q &&
		avs_address == `PAF_A_ADAT |-> avs_readdata == 32'h0)
		else $error("array read while secure");
	diag_off_a: assert property (rd && !diag_q &&
		avs_address == `PAF_A_DIAG |-> avs_readdata == 32'h0)
		else $error("diag read while off");
endmodule // paf_assertions
bind paf_top paf_assertions i_chk (.clock, .rst_b, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .io_pin_out, .io_pin_oe);

//--- paf_board.sv
// Board model: input drivers, pin clocks, pull-ups
module paf_board (
	// From bench
	input wire [9:0] in_val,
	input wire icl,
	input wire ocl,
	// Device pins
	input wire [9:0] io_pin_out,
	input wire [9:0] io_pin_oe,
	output wire [9:0] in_pin,
	output wire [9:0] io_pin_in,
	output wire input_register_clock,
	output wire output_register_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pins float high
	assign io_pin_in = (io_pin_oe & io_pin_out) | ~io_pin_oe;
	assign in_pin = in_val;
	// Clocks stay static unless asked
	assign input_register_clock = icl;
	assign output_register_clock = ocl;
endmodule // paf_board

//--- tb_top.sv
// Top-level bench for the array fabric
`include "paf_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_b, avs_read, avs_write, icl, ocl;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, q;
	logic [9:0] in_val;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, input_register_clock, output_register_clock;
	wire [9:0] in_pin, io_pin_in, io_pin_out, io_pin_oe;
	int n_errors, check_count;
	paf_top i_paf_top (.clock, .rst_b, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.in_pin, .io_pin_in, .io_pin_out, .io_pin_oe,
		.input_register_clock, .output_register_clock);
	paf_board i_paf_board (.in_val, .icl, .ocl, .io_pin_out, .io_pin_oe,
		.in_pin, .io_pin_in, .input_register_clock,
		.output_register_clock);
	initial
	begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input string n, input logic [31:0] e, s);
		check_count++;
		if (s !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			n_errors++;
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		// One wait state: answer at the second edge
		chk("bus edges", 32'h2, k);
	endtask
	// Pin clock pulse, then time for sync and cell update
	task automatic pin_clock(input logic outc);
		if (outc)
			ocl <= 1'b1;
		else
			icl <= 1'b1;
		repeat (3) @(posedge clock);
		ocl <= 1'b0;
		icl <= 1'b0;
		repeat (8) @(posedge clock);
	endtask
	task final_report;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task t_power;
		bus(0, `PAF_A_STAT, 0);
		chk("ready early", 0, q[1]);
		chk("pins", 10'h3FF, io_pin_out);
		chk("oe", 0, io_pin_oe);
		repeat (210) @(posedge clock);
		bus(0, `PAF_A_STAT, 0);
		chk("ready", 1, q[1]);
		$display("t_power done");
	endtask
	task t_sig;
		bus(1, `PAF_A_SSEL, 0);
		bus(1, `PAF_A_SDAT, 32'h12345678);
		bus(1, `PAF_A_SSEL, 2);
		bus(1, `PAF_A_SDAT, 32'h000001AB);
		bus(0, `PAF_A_SDAT, 0);
		chk("sig2", 32'h000000AB, q);
		bus(0, `PAF_A_CSUM, 0);
		chk("csum", 32'h12345723, q);
		$display("t_sig done");
	endtask
	task t_array;
		// Term 65 word 1: complement of input cell 0
		bus(1, `PAF_A_ASEL, 32'h141);
		bus(1, `PAF_A_ADAT, 32'h80);
		bus(0, `PAF_A_ADAT, 0);
		chk("and word", 32'h80, q);
		chk("oe", 10'h001, io_pin_oe);
		bus(0, `PAF_A_CSUM, 0);
		chk("csum and", 32'h123457A3, q);
		pin_clock(1'b0);
		chk("oe sampled", 0, io_pin_oe);
		$display("t_array done");
	endtask
	task t_preload;
		bus(1, `PAF_A_PLO, 32'h00100000);
		// Buried cell 17 sits in the top preload bit
		bus(1, `PAF_A_PHI, 32'h00000020);
		bus(1, `PAF_A_CTRL, 4);
		repeat (2) @(posedge clock);
		chk("pre out", 10'h3FE, io_pin_out);
		chk("pre oe", 10'h001, io_pin_oe);
		chk("pin in", 10'h3FE, io_pin_in);
		bus(0, `PAF_A_DIAG, 0);
		chk("diag off", 0, q);
		bus(1, `PAF_A_CTRL, 8);
		bus(0, `PAF_A_DIAG, 0);
		chk("diag on", 32'h00020001, q);
		bus(1, `PAF_A_CTRL, 0);
		$display("t_preload done");
	endtask
	task t_secure;
		bus(1, `PAF_A_CTRL, 1);
		bus(0, `PAF_A_STAT, 0);
		chk("secure", 1, q[0]);
		bus(0, `PAF_A_ADAT, 0);
		chk("and hidden", 0, q);
		bus(1, `PAF_A_SSEL, 0);
		bus(0, `PAF_A_SDAT, 0);
		chk("sig seen", 32'h12345678, q);
		bus(1, `PAF_A_CTRL, 0);
		bus(0, `PAF_A_STAT, 0);
		chk("secure kept", 1, q[0]);
		bus(1, `PAF_A_CTRL, 2);
		bus(0, `PAF_A_STAT, 0);
		chk("erased", 0, q[0]);
		bus(0, `PAF_A_SDAT, 0);
		chk("sig erased", 0, q);
		chk("oe erased", 0, io_pin_oe);
		bus(1, 8'h30, 32'hFFFFFFFF);
		bus(0, 8'h30, 0);
		chk("unmapped", 0, q);
		$display("t_secure done");
	endtask
	task t_cells;
		// Erase leaves the cells alone
		chk("cell kept", 10'h3FE, io_pin_out);
		// Reset term on complement of input cell 0, now low
		bus(1, `PAF_A_ASEL, 32'h140);
		bus(1, `PAF_A_ADAT, 32'h80);
		repeat (2) @(posedge clock);
		chk("reset term", 10'h3FF, io_pin_out);
		// Term 0 and enable term 65 both follow input cell 0
		bus(1, `PAF_A_ASEL, 32'h000);
		bus(1, `PAF_A_ADAT, 32'h1);
		bus(1, `PAF_A_ASEL, 32'h041);
		bus(1, `PAF_A_ADAT, 32'h1);
		// Data sum 0 takes terms 0 to 31, enable sum 18 only term 0
		bus(1, `PAF_A_OSEL, 32'h00);
		bus(1, `PAF_A_ODAT, 32'hFFFFFFFF);
		bus(0, `PAF_A_ODAT, 0);
		chk("or word", 32'hFFFFFFFF, q);
		bus(1, `PAF_A_OSEL, 32'h12);
		bus(1, `PAF_A_ODAT, 32'h1);
		bus(0, `PAF_A_CSUM, 0);
		chk("csum cells", 32'h00000082, q);
		pin_clock(1'b1);
		chk("held in reset", 10'h3FF, io_pin_out);
		pin_clock(1'b0);
		chk("oe on", 10'h001, io_pin_oe);
		chk("not clocked", 10'h3FF, io_pin_out);
		pin_clock(1'b1);
		chk("cell set", 10'h3FE, io_pin_out);
		chk("pin driven", 10'h3FE, io_pin_in);
		bus(1, `PAF_A_CTRL, 8);
		bus(0, `PAF_A_DIAG, 0);
		chk("diag cells", 32'h00000001, q);
		bus(1, `PAF_A_CTRL, 0);
		$display("t_cells done");
	endtask
	initial
	begin
		{rst_b, avs_read, avs_write, icl, ocl} = 0;
		avs_address = 0;
		avs_writedata = 0;
		in_val = 10'h3FF;
		repeat (8) @(posedge clock);
		rst_b <= 1;
		t_power;
		t_sig;
		t_array;
		t_preload;
		t_secure;
		t_cells;
		final_report;
	end
	initial
	begin
		#25000;
		n_errors++;
		final_report;
	end
endmodule // tb_top
